// ### core/rsc_pkg.sv
// Constants for the reset source and flag controller
package rsc_pkg;

    // ------------------------------------------------------------
    // Register port geometry and offsets
    // ------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [2:0] ADDR_DUR = 3'h0;      // low_voltage_duration_select
    localparam logic [2:0] ADDR_FLAGS = 3'h1;    // reset_cause_flags
    localparam logic [2:0] ADDR_THR = 3'h2;      // threshold_select
    localparam logic [2:0] ADDR_FPC1 = 3'h3;     // flash_prog_control_1
    localparam logic [2:0] ADDR_STAT = 3'h4;     // timeout / power-down flags
    localparam logic [2:0] ADDR_IRQ_ST = 3'h5;   // sticky event status
    localparam logic [2:0] ADDR_IRQ_MSK = 3'h6;  // event mask

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [1:0] DUR_RST = 2'h1;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [7:0] THR_RST = 8'h55;
    localparam logic [7:0] THR_CODE_A = 8'h55;
    localparam logic [7:0] THR_CODE_B = 8'h33;
    localparam logic [7:0] THR_CODE_C = 8'h99;
    localparam logic [7:0] THR_CODE_D = 8'hAA;
    localparam logic [7:0] FPC1_RST = 8'h00;
    localparam logic [7:0] IAP_MAGIC = 8'h55;
    localparam logic [3:0] IRQ_RST = 4'h0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FLG_WDT_CORR = 0;   // watchdog_control_corruption_flag
    localparam int FLG_THR_CORR = 1;   // threshold_select_corruption_flag
    localparam int FLG_LVR = 2;        // supply_low_reset_flag
    localparam int FLG_RST_CORR = 3;   // reset_control_corruption_flag
    localparam int STAT_TO = 0;        // timeout_flag
    localparam int STAT_PD = 1;        // power_down_flag
    localparam int EV_LVR = 0;
    localparam int EV_THR = 1;
    localparam int EV_IAP = 2;
    localparam int EV_WDT = 3;

    // ------------------------------------------------------------
    // Low-speed oscillator edge counts per duration code
    // ------------------------------------------------------------
    localparam logic [7:0] DUR_EDGES_0 = 8'h08;
    localparam logic [7:0] DUR_EDGES_1 = 8'h20;
    localparam logic [7:0] DUR_EDGES_2 = 8'h40;
    localparam logic [7:0] DUR_EDGES_3 = 8'h80;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int SRESET_NS = 1000;   // software-reset delay
    localparam int SRESET_CYC = (SRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] SRESET_LAST = 5'(SRESET_CYC - 1);

endpackage

// ### core/rsc_reset_ctrl.sv
// Reset source handling: supply-low filter, cause flags, reset requests
//
// Function
// - Duration code selects 8/32/64/128 oscillator edges.
// - Unimplemented upper register bits read as zero.
// - Supply-low reset sets sticky flag; software clears.
// - Bad threshold code sets sticky corruption flag.
// - Writing 55H to programming control resets.
// - Running watchdog timeout: full reset, timeout set.
// - Sleeping watchdog timeout: clear PC/SP, set both.
// - Power-on clears flags; supply-low reset keeps them.
// - Power-on reset initialises core through full reset.
// - Supply-low reset only after full duration elapses.
// - Bad threshold resets after delay, restores value.
`timescale 1ns/1ps
`default_nettype none

module rsc_reset_ctrl (
    // Clock and power-on reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [2:0] addr_i,
    input wire logic [7:0] write_data_i,
    input wire logic write_strobe_i,
    input wire logic read_strobe_i,
    output logic [7:0] read_data_o,
    // Analog and oscillator pins
    input wire logic supply_low_i,
    input wire logic low_speed_osc_i,
    // Core status and events
    input wire logic low_power_i,
    input wire logic wdt_timeout_i,
    input wire logic wdt_ctrl_corrupt_i,
    input wire logic reset_ctrl_corrupt_i,
    // Reset requests and flags
    output logic full_reset_o,
    output logic pc_sp_clear_o,
    output logic timeout_flag_o,
    output logic power_down_flag_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic osc_s1;
        logic osc_s2;
        logic osc_s3;
        logic sup_s1;
        logic sup_s2;
        logic [7:0] lv_cnt;
        logic lv_fired;
        logic [4:0] thr_cnt;
        logic [1:0] dur;
        logic [3:0] flags;
        logic [7:0] thr;
        logic [7:0] fpc1;
        logic to_flag;
        logic pd_flag;
        logic [3:0] irq_st;
        logic [3:0] irq_msk;
        logic [7:0] rdata;
        logic full_rst;
        logic pcsp_clr;
    } rsc_state_s;

    localparam rsc_state_s STATE_RST = '{
        osc_s1: 1'b0, osc_s2: 1'b0, osc_s3: 1'b0, sup_s1: 1'b0, sup_s2: 1'b0,
        lv_cnt: 8'h00, lv_fired: 1'b0, thr_cnt: 5'h00,
        dur: rsc_pkg::DUR_RST, flags: rsc_pkg::FLAGS_RST,
        thr: rsc_pkg::THR_RST, fpc1: rsc_pkg::FPC1_RST,
        to_flag: 1'b0, pd_flag: 1'b0,
        irq_st: rsc_pkg::IRQ_RST, irq_msk: rsc_pkg::IRQ_RST,
        rdata: 8'h00, full_rst: 1'b1, pcsp_clr: 1'b1
    };

    rsc_state_s q;
    rsc_state_s d;

    // ------------------------------------------------------------
    // Decoders
    // ------------------------------------------------------------

    // Edge count for a duration code
    function automatic logic [7:0] dur_limit(input logic [1:0] code);
        unique case (code)
            2'h0: dur_limit = rsc_pkg::DUR_EDGES_0;
            2'h1: dur_limit = rsc_pkg::DUR_EDGES_1;
            2'h2: dur_limit = rsc_pkg::DUR_EDGES_2;
            2'h3: dur_limit = rsc_pkg::DUR_EDGES_3;
        endcase
    endfunction

    // Only four threshold codes are legal
    function automatic logic thr_valid(input logic [7:0] code);
        thr_valid = (code == rsc_pkg::THR_CODE_A) || (code == rsc_pkg::THR_CODE_B) ||
            (code == rsc_pkg::THR_CODE_C) || (code == rsc_pkg::THR_CODE_D);
    endfunction

    // ------------------------------------------------------------
    // Events
    // ------------------------------------------------------------
    logic osc_edge;
    logic lvr_evt;
    logic thr_evt;
    logic iap_evt;
    logic wdt_run_evt;
    logic wdt_slp_evt;
    logic [3:0] ev_vec;
    logic wr_sel_flags;

    // Rising edge seen on the second and third sync stages only
    assign osc_edge = q.osc_s2 & ~q.osc_s3;
    // Monitor is off in sleep/idle, so a dip there never resets
    // At or past the limit: a code lowered mid-dip must not wait for a wrap
    assign lvr_evt = q.sup_s2 && !low_power_i && osc_edge && !q.lv_fired &&
        (q.lv_cnt >= dur_limit(q.dur) - 8'h01);
    assign thr_evt = !thr_valid(q.thr) && (q.thr_cnt == rsc_pkg::SRESET_LAST);
    assign iap_evt = write_strobe_i && (addr_i == rsc_pkg::ADDR_FPC1) &&
        (write_data_i == rsc_pkg::IAP_MAGIC);
    assign wdt_run_evt = wdt_timeout_i && !low_power_i;
    assign wdt_slp_evt = wdt_timeout_i && low_power_i;
    // Software write to the cause flags
    assign wr_sel_flags = write_strobe_i && (addr_i == rsc_pkg::ADDR_FLAGS);

    // Events gathered for the interrupt status
    always_comb begin
        ev_vec = 4'h0;
        ev_vec[rsc_pkg::EV_LVR] = lvr_evt;
        ev_vec[rsc_pkg::EV_THR] = thr_evt;
        ev_vec[rsc_pkg::EV_IAP] = iap_evt;
        ev_vec[rsc_pkg::EV_WDT] = wdt_timeout_i;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic wr_flags;
        logic [7:0] rd;
        wr_flags = write_strobe_i && (addr_i == rsc_pkg::ADDR_FLAGS);
        rd = 8'h00;
        d = q;

        // Two-stage synchronisers, third stage only for edge detect
        d.osc_s1 = low_speed_osc_i;
        d.osc_s2 = q.osc_s1;
        d.osc_s3 = q.osc_s2;
        d.sup_s1 = supply_low_i;
        d.sup_s2 = q.sup_s1;

        // Duration counter; one reset per dip, rearmed on recovery
        if (!q.sup_s2 || low_power_i) begin
            d.lv_cnt = 8'h00;
            d.lv_fired = 1'b0;
        end else if (lvr_evt) begin
            d.lv_cnt = 8'h00;
            d.lv_fired = 1'b1;
        end else if (osc_edge && !q.lv_fired) begin
            d.lv_cnt = q.lv_cnt + 8'h01;
        end

        // Software-reset delay for a corrupted threshold code
        if (thr_valid(q.thr) || thr_evt) begin
            d.thr_cnt = 5'h00;
        end else begin
            d.thr_cnt = q.thr_cnt + 5'h01;
        end

        // Register writes
        if (write_strobe_i) begin
            unique case (addr_i)
                rsc_pkg::ADDR_DUR: d.dur = write_data_i[1:0];
                rsc_pkg::ADDR_THR: d.thr = write_data_i;
                rsc_pkg::ADDR_FPC1: d.fpc1 = write_data_i;
                rsc_pkg::ADDR_STAT: begin
                    d.to_flag = q.to_flag & write_data_i[rsc_pkg::STAT_TO];
                    d.pd_flag = q.pd_flag & write_data_i[rsc_pkg::STAT_PD];
                end
                rsc_pkg::ADDR_IRQ_ST: d.irq_st = q.irq_st & ~write_data_i[3:0];
                rsc_pkg::ADDR_IRQ_MSK: d.irq_msk = write_data_i[3:0];
                default: d.rdata = d.rdata;
            endcase
        end

        // Cause flags: writing zero clears, a same-cycle set wins
        d.flags = wr_flags ? (q.flags & write_data_i[3:0]) : q.flags;
        d.flags[rsc_pkg::FLG_LVR] = d.flags[rsc_pkg::FLG_LVR] | lvr_evt;
        d.flags[rsc_pkg::FLG_THR_CORR] = d.flags[rsc_pkg::FLG_THR_CORR] | thr_evt;
        d.flags[rsc_pkg::FLG_WDT_CORR] = d.flags[rsc_pkg::FLG_WDT_CORR] | wdt_ctrl_corrupt_i;
        d.flags[rsc_pkg::FLG_RST_CORR] = d.flags[rsc_pkg::FLG_RST_CORR] | reset_ctrl_corrupt_i;

        // Corrupted threshold falls back to its power-on code
        if (thr_evt) begin
            d.thr = rsc_pkg::THR_RST;
        end

        // Timeout and power-down; a supply-low reset leaves both alone
        if (wdt_timeout_i) begin
            d.to_flag = 1'b1;
        end
        if (wdt_slp_evt) begin
            d.pd_flag = 1'b1;
        end

        // Sticky event status, set beats write-one clear
        d.irq_st = d.irq_st | ev_vec;

        // Reset requests, one cycle each
        d.full_rst = lvr_evt || thr_evt || iap_evt || wdt_run_evt;
        d.pcsp_clr = d.full_rst || wdt_slp_evt;

        // Read data stand only in the cycle after the strobe
        if (read_strobe_i) begin
            unique case (addr_i)
                rsc_pkg::ADDR_DUR: rd = {6'h00, q.dur};
                rsc_pkg::ADDR_FLAGS: rd = {4'h0, q.flags};
                rsc_pkg::ADDR_THR: rd = q.thr;
                rsc_pkg::ADDR_FPC1: rd = q.fpc1;
                rsc_pkg::ADDR_STAT: rd = {6'h00, q.pd_flag, q.to_flag};
                rsc_pkg::ADDR_IRQ_ST: rd = {4'h0, q.irq_st};
                rsc_pkg::ADDR_IRQ_MSK: rd = {4'h0, q.irq_msk};
                default: rd = 8'h00;
            endcase
        end
        d.rdata = rd;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Power-on: flags cleared, reset requests held through release
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs
    assign read_data_o = q.rdata;
    assign full_reset_o = q.full_rst;
    assign pc_sp_clear_o = q.pcsp_clr;
    assign timeout_flag_o = q.to_flag;
    assign power_down_flag_o = q.pd_flag;
    // Level interrupt while any unmasked event is pending
    assign irq_o = |(q.irq_st & q.irq_msk);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    property p_dur_count;
        lvr_evt |-> osc_edge && q.sup_s2 && (q.lv_cnt >= dur_limit(q.dur) - 8'h01);
    endproperty
    a_dur_count: assert property (p_dur_count) else $error("supply-low count wrong");

    property p_rsvd_zero;
        read_strobe_i && (addr_i == rsc_pkg::ADDR_DUR) |=> read_data_o[7:2] == 6'h00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");

    property p_lvr_flag;
        lvr_evt |=> q.flags[rsc_pkg::FLG_LVR] && full_reset_o;
    endproperty
    a_lvr_flag: assert property (p_lvr_flag) else $error("supply-low flag not set");

    property p_lvr_keep;
        $fell(q.flags[rsc_pkg::FLG_LVR]) |->
            $past(wr_sel_flags) && !$past(write_data_i[rsc_pkg::FLG_LVR]);
    endproperty
    a_lvr_keep: assert property (p_lvr_keep) else $error("flag cleared by hardware");

    property p_thr_corrupt;
        !thr_valid(q.thr) ##1 !thr_valid(q.thr) [*8] |->
            ##[1:20] q.flags[rsc_pkg::FLG_THR_CORR] &&
            q.thr == rsc_pkg::THR_RST;
    endproperty
    a_thr_corrupt: assert property (p_thr_corrupt) else $error("bad threshold kept");

    property p_iap;
        iap_evt |=> full_reset_o ##1 !full_reset_o;
    endproperty
    a_iap: assert property (p_iap) else $error("programming reset missing");

    property p_wdt_run;
        wdt_run_evt |=> full_reset_o && timeout_flag_o && pc_sp_clear_o;
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("running timeout wrong");

    property p_wdt_sleep;
        wdt_slp_evt && !lvr_evt && !thr_evt && !iap_evt |=>
            pc_sp_clear_o && !full_reset_o && timeout_flag_o && power_down_flag_o;
    endproperty
    a_wdt_sleep: assert property (p_wdt_sleep) else $error("sleep timeout wrong");

    property p_lvr_flags_kept;
        lvr_evt && !wdt_timeout_i && !write_strobe_i |=>
            $stable(timeout_flag_o) && $stable(power_down_flag_o);
    endproperty
    a_lvr_flags_kept: assert property (p_lvr_flags_kept) else $error("flags moved");

    property p_recover;
        !q.sup_s2 |=> q.lv_cnt == 8'h00 && !lvr_evt;
    endproperty
    a_recover: assert property (p_recover) else $error("counter not restarted");

    // Corrupted threshold: restore, flag and reset together
    property p_thr_restore;
        thr_evt |=> q.thr == rsc_pkg::THR_RST && q.flags[rsc_pkg::FLG_THR_CORR] && full_reset_o;
    endproperty
    a_thr_restore: assert property (p_thr_restore) else $error("threshold not restored");

    property p_pcsp_full;
        full_reset_o |-> pc_sp_clear_o;
    endproperty
    a_pcsp_full: assert property (p_pcsp_full) else $error("full reset without PC clear");

    property p_flags_rsvd;
        read_strobe_i && (addr_i == rsc_pkg::ADDR_FLAGS) |=> read_data_o[7:4] == 4'h0;
    endproperty
    a_flags_rsvd: assert property (p_flags_rsvd) else $error("flag upper bits nonzero");

    property p_rdata_idle;
        !read_strobe_i |=> read_data_o == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");

    c_lvr: cover property (lvr_evt ##1 full_reset_o);
    c_thr: cover property (thr_evt);
    c_sleep: cover property (wdt_slp_evt ##1 pc_sp_clear_o);
    c_irq: cover property ($rose(irq_o));
    c_iap: cover property (iap_evt ##1 full_reset_o);

endmodule

`default_nettype wire

// ### verification/rsc_reset_ctrl_tb.sv
// Self-checking testbench for the reset source and flag controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin err_total++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end

module rsc_reset_ctrl_tb;
    // ------------------------------------------------------------
    // Signals and counters
    // ------------------------------------------------------------
    logic clk_i;
    logic reset_i;
    logic [2:0] addr_i;
    logic [7:0] write_data_i;
    logic write_strobe_i;
    logic read_strobe_i;
    logic [7:0] read_data_o;
    logic supply_low_i;
    logic low_speed_osc_i;
    logic low_power_i;
    logic wdt_timeout_i;
    logic wdt_ctrl_corrupt_i;
    logic reset_ctrl_corrupt_i;
    logic full_reset_o;
    logic pc_sp_clear_o;
    logic timeout_flag_o;
    logic power_down_flag_o;
    logic irq_o;
    int err_total = 0;
    int checks = 0;
    int fr_cnt = 0;
    int pc_cnt = 0;
    int fr0;
    int pc0;
    int n;
    logic [7:0] codes [4];

    rsc_reset_ctrl dut (
        .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .write_data_i(write_data_i),
        .write_strobe_i(write_strobe_i), .read_strobe_i(read_strobe_i),
        .read_data_o(read_data_o), .supply_low_i(supply_low_i),
        .low_speed_osc_i(low_speed_osc_i), .low_power_i(low_power_i),
        .wdt_timeout_i(wdt_timeout_i), .wdt_ctrl_corrupt_i(wdt_ctrl_corrupt_i),
        .reset_ctrl_corrupt_i(reset_ctrl_corrupt_i), .full_reset_o(full_reset_o),
        .pc_sp_clear_o(pc_sp_clear_o), .timeout_flag_o(timeout_flag_o),
        .power_down_flag_o(power_down_flag_o), .irq_o(irq_o)
    );

    // Clock, 50 ns period
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Count reset pulses outside power-on reset; pulses last one cycle only
    always @(posedge clk_i) begin
        if (!reset_i && full_reset_o === 1'b1) fr_cnt++;
        if (!reset_i && pc_sp_clear_o === 1'b1) pc_cnt++;
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        write_data_i <= d;
        write_strobe_i <= 1'b1;
        @(posedge clk_i);
        write_strobe_i <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] ex, input string nm);
        @(posedge clk_i);
        addr_i <= a;
        read_strobe_i <= 1'b1;
        @(posedge clk_i);
        read_strobe_i <= 1'b0;
        #1;
        `CHK(nm, ex, read_data_o)
    endtask

    // Oscillator edges, slow against the system clock like the real source
    task automatic osc(input int k);
        repeat (k) begin
            @(posedge clk_i);
            low_speed_osc_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            low_speed_osc_i <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask

    task automatic wdt(input logic lp);
        @(posedge clk_i);
        low_power_i <= lp;
        wdt_timeout_i <= 1'b1;
        @(posedge clk_i);
        wdt_timeout_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog against a hung run; tests need about 4000 cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        err_total++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        reset_i = 1'b1;
        addr_i = 3'h0;
        write_data_i = 8'h00;
        write_strobe_i = 1'b0;
        read_strobe_i = 1'b0;
        supply_low_i = 1'b0;
        low_speed_osc_i = 1'b0;
        low_power_i = 1'b0;
        wdt_timeout_i = 1'b0;
        wdt_ctrl_corrupt_i = 1'b0;
        reset_ctrl_corrupt_i = 1'b0;
        codes = '{rsc_pkg::THR_CODE_A, rsc_pkg::THR_CODE_B, rsc_pkg::THR_CODE_C,
                  rsc_pkg::THR_CODE_D};
        repeat (8) @(posedge clk_i);
        `CHK("reset request in reset", 1'b1, full_reset_o)
        reset_i <= 1'b0;
        rd(rsc_pkg::ADDR_DUR, 8'h01, "duration");
        rd(rsc_pkg::ADDR_FLAGS, 8'h00, "flags");
        rd(rsc_pkg::ADDR_THR, 8'h55, "threshold");
        rd(rsc_pkg::ADDR_STAT, 8'h00, "status");
        wr(rsc_pkg::ADDR_DUR, 8'hFF);
        rd(rsc_pkg::ADDR_DUR, 8'h03, "duration upper");
        wr(3'h7, 8'hFF);
        rd(3'h7, 8'h00, "unmapped");
        // Running watchdog timeout: full reset plus timeout flag
        fr0 = fr_cnt;
        pc0 = pc_cnt;
        wdt(1'b0);
        `CHK("run wdt reset", fr0 + 1, fr_cnt)
        `CHK("run wdt pc clear", pc0 + 1, pc_cnt)
        `CHK("run wdt timeout", 1'b1, timeout_flag_o)
        `CHK("run wdt pd", 1'b0, power_down_flag_o)
        // Each duration code: a too-short dip, recovery, then a full dip
        for (int c = 0; c < 4; c++) begin
            n = (c == 0) ? 8 : (16 << c);
            wr(rsc_pkg::ADDR_DUR, 8'(c));
            fr0 = fr_cnt;
            @(posedge clk_i);
            supply_low_i <= 1'b1;
            repeat (3) @(posedge clk_i);
            osc(n - 1);
            supply_low_i <= 1'b0;
            repeat (6) @(posedge clk_i);
            supply_low_i <= 1'b1;
            repeat (3) @(posedge clk_i);
            osc(n - 1);
            repeat (6) @(posedge clk_i);
            `CHK("short dip", fr0, fr_cnt)
            osc(1);
            `CHK("long dip", fr0 + 1, fr_cnt)
            supply_low_i <= 1'b0;
            rd(rsc_pkg::ADDR_FLAGS, 8'h04, "supply flag");
        end
        `CHK("timeout kept", 1'b1, timeout_flag_o)
        `CHK("pd kept", 1'b0, power_down_flag_o)
        // Interrupt: mask, unmask, clear by writing one
        wr(rsc_pkg::ADDR_IRQ_MSK, 8'h01);
        `CHK("irq unmasked", 1'b1, irq_o)
        wr(rsc_pkg::ADDR_IRQ_MSK, 8'h00);
        `CHK("irq masked", 1'b0, irq_o)
        wr(rsc_pkg::ADDR_IRQ_MSK, 8'h01);
        wr(rsc_pkg::ADDR_IRQ_ST, 8'h01);
        `CHK("irq cleared", 1'b0, irq_o)
        rd(rsc_pkg::ADDR_IRQ_ST, 8'h08, "event status");
        rd(rsc_pkg::ADDR_IRQ_MSK, 8'h01, "event mask");
        wr(rsc_pkg::ADDR_FLAGS, 8'hF0);
        rd(rsc_pkg::ADDR_FLAGS, 8'h00, "flags cleared");
        // Valid threshold codes never reset; a bad one does after the delay
        fr0 = fr_cnt;
        for (int i = 0; i < 4; i++) begin
            wr(rsc_pkg::ADDR_THR, codes[i]);
            rd(rsc_pkg::ADDR_THR, codes[i], "threshold code");
        end
        repeat (25) @(posedge clk_i);
        `CHK("valid code", fr0, fr_cnt)
        wr(rsc_pkg::ADDR_THR, 8'h12);
        repeat (15) @(posedge clk_i);
        `CHK("bad code early", fr0, fr_cnt)
        repeat (10) @(posedge clk_i);
        `CHK("bad code reset", fr0 + 1, fr_cnt)
        rd(rsc_pkg::ADDR_THR, 8'h55, "threshold restored");
        rd(rsc_pkg::ADDR_FLAGS, 8'h02, "threshold flag");
        // Programming control: only the magic value resets
        wr(rsc_pkg::ADDR_FPC1, 8'h54);
        repeat (3) @(posedge clk_i);
        `CHK("no magic", fr0 + 1, fr_cnt)
        wr(rsc_pkg::ADDR_FPC1, rsc_pkg::IAP_MAGIC);
        repeat (2) @(posedge clk_i);
        `CHK("magic reset", fr0 + 2, fr_cnt)
        rd(rsc_pkg::ADDR_FPC1, rsc_pkg::IAP_MAGIC, "prog control");
        // Corruption event pulses set their own flag bits
        @(posedge clk_i);
        wdt_ctrl_corrupt_i <= 1'b1;
        reset_ctrl_corrupt_i <= 1'b1;
        @(posedge clk_i);
        wdt_ctrl_corrupt_i <= 1'b0;
        reset_ctrl_corrupt_i <= 1'b0;
        rd(rsc_pkg::ADDR_FLAGS, 8'h0B, "corruption flags");
        // Sleeping watchdog timeout: only PC/SP clear, both flags set
        wr(rsc_pkg::ADDR_STAT, 8'h00);
        rd(rsc_pkg::ADDR_STAT, 8'h00, "status cleared");
        fr0 = fr_cnt;
        pc0 = pc_cnt;
        wdt(1'b1);
        `CHK("sleep wdt no reset", fr0, fr_cnt)
        `CHK("sleep wdt pc clear", pc0 + 1, pc_cnt)
        @(posedge clk_i);
        low_power_i <= 1'b0;
        rd(rsc_pkg::ADDR_STAT, 8'h03, "sleep status");
        rd(rsc_pkg::ADDR_THR, 8'h55, "sleep keeps");
        // Second power-on reset clears the flags
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(rsc_pkg::ADDR_STAT, 8'h00, "por status");
        rd(rsc_pkg::ADDR_FLAGS, 8'h00, "por flags");
        rd(rsc_pkg::ADDR_DUR, 8'h01, "por duration");
        wrap_up();
    end
endmodule
`default_nettype wire
